//--- ctd_cfg.svh
// Summary of operation
// - one 14-bit word holds opcode and operands
// - direct and computed calls take two cycles
// - all three returns take two cycles
// - taken jumps, branches, skips take two cycles
// - indirect access to program space adds cycle
// - one instruction cycle is four clocks
// - file instructions read before they store
// - destination bit: 0 accumulator, 1 file
// - file address field covers 0x00 to 0x7f
// - bit field picks one of eight bits
// - don't-care opcode bits are ignored
// - pointer number selects pointer 0 or 1
// - mode 00/01/10/11 pre/post inc/dec, offset -32..31
// - indirect store writes accumulator via pointer
// - window addresses redirect through their pointer
// - pointers are 16 bits and wrap
// - pointer update leaves status flags alone
`ifndef CTD_CFG_SVH
`define CTD_CFG_SVH

`define CTD_CLK_MHZ      250
`define CTD_OSC_PER_ICYC 4
`define CTD_PHASE_LAST   2'h3

`define CTD_ADDR_INSTR   6'h00
`define CTD_ADDR_ACC     6'h01
`define CTD_ADDR_PTR0    6'h02
`define CTD_ADDR_PTR1    6'h03
`define CTD_ADDR_STAT    6'h04
`define CTD_ADDR_PC      6'h05
`define CTD_HSIZE_WORD   3'h2

`define CTD_RST_ACC      8'h00
`define CTD_RST_PTR      16'h0000
`define CTD_RST_PC       11'h000

`define CTD_CAT          13:12
`define CTD_OP           11:8
`define CTD_BOP          11:10
`define CTD_BIT          9:7
`define CTD_FILE         6:0
`define CTD_DEST         7
`define CTD_K11          10:0
`define CTD_K9           8:0
`define CTD_K8           7:0
`define CTD_N_MM         2
`define CTD_MM           1:0
`define CTD_N_K          6
`define CTD_K6           5:0
`define CTD_PM_BIT       15

`define CTD_CAT_BYTE     2'h0
`define CTD_CAT_BIT      2'h1
`define CTD_CAT_CTRL     2'h2
`define CTD_CAT_LIT      2'h3

`define CTD_OP_MOVF      4'h0
`define CTD_OP_INCF      4'h1
`define CTD_OP_DECF      4'h2
`define CTD_OP_CLRF      4'h3
`define CTD_OP_ADDWF     4'h4
`define CTD_OP_DECSZ     4'h5
`define CTD_OP_INCSZ     4'h6
`define CTD_OP_MOVWF     4'h7

`define CTD_BOP_SET      2'h0
`define CTD_BOP_CLR      2'h1
`define CTD_BOP_SKIPCLR  2'h2
`define CTD_BOP_SKIPSET  2'h3

`define CTD_OP_NOP       4'h0
`define CTD_OP_JUMP      4'h1
`define CTD_OP_CALL      4'h2
`define CTD_OP_COMPUTED_SUBROUTINE_JUMP     4'h3
`define CTD_OP_RET       4'h4
`define CTD_OP_RETLIT    4'h5
`define CTD_OP_RETINT    4'h6
`define CTD_OP_BRANCH    4'h7
`define CTD_OP_BRANCHW   4'h8

`define CTD_OP_MOVLW     4'h0
`define CTD_OP_STMODE    4'h1
`define CTD_OP_STOFFS    4'h2

`define CTD_MM_PREINC    2'h0
`define CTD_MM_PREDEC    2'h1
`define CTD_MM_POSTINC   2'h2
`define CTD_MM_POSTDEC   2'h3

`define CTD_WIN0         7'h00
`define CTD_WIN1         7'h01
`define CTD_RAM_DEPTH    128

`endif

//--- ctd_pkg.sv
package ctd_pkg;

  typedef enum logic [1:0] {st_idle, st_first, st_extra} ctd_state_t;

  typedef struct packed {
    logic       pend;
    logic       wr;
    logic [5:0] idx;
  } ctd_bus_t;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } ctd_wr_t;

  typedef struct packed {
    ctd_state_t  st;
    ctd_bus_t    bus;
    logic        hready;
    logic [31:0] hrdata;
    logic        hresp;
    logic [13:0] ir;
    logic [7:0]  acc;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [10:0] pc;
    logic [10:0] stk;
    logic        z;
    logic        c;
    logic        dc;
    logic [1:0]  cyc_left;
    logic [2:0]  last_cyc;
  } ctd_core_t;

endpackage

//--- ctd_file_ram.sv
`timescale 1ns/10ps
`include "ctd_cfg.svh"
module ctd_file_ram (
  input  wire logic           core_clk,
  input  wire logic           rd_en,
  input  wire logic [6:0]     rd_addr,
  input  wire ctd_pkg::ctd_wr_t wr,
  output logic [7:0]          rd_data
);
  logic [7:0] mem [`CTD_RAM_DEPTH];
  logic [7:0] rd_data_reg;

  // no reset on the array: file register contents are undefined after reset
  always_ff @(posedge core_clk) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.data;
    end
    if (rd_en) begin
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;
endmodule // ctd_file_ram

//--- ctd_phase.sv
`timescale 1ns/10ps
`include "ctd_cfg.svh"
module ctd_phase (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  output logic [1:0]      phase,
  output logic            cyc_end
);
  logic [1:0] phase_reg;
  logic [1:0] phase_next;

  // held at zero while idle so every instruction starts on its first quarter
  always_comb begin
    phase_next = run ? phase_reg + 2'h1 : 2'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase   = phase_reg;
  assign cyc_end = run && (phase_reg == `CTD_PHASE_LAST);
endmodule // ctd_phase

//--- ctd_core.sv
`timescale 1ns/10ps
`include "ctd_cfg.svh"
module ctd_core (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);
  ctd_pkg::ctd_core_t s;
  ctd_pkg::ctd_core_t n;
  ctd_pkg::ctd_wr_t   wr;
  logic               rd_en;
  logic [6:0]         rd_addr;
  logic [7:0]         rd_data;
  logic [1:0]         phase;
  logic               cyc_end;
  logic               busy;
  logic [1:0]         cat;
  logic [3:0]         op;
  logic               is_file;
  logic               is_st;
  logic               ind;
  logic               psel;
  logic [15:0]        ptr;
  logic [15:0]        ea;
  logic [15:0]        ptr_new;
  logic               pm;
  logic [7:0]         opnd;
  logic [7:0]         res;
  logic               to_file;
  logic               to_acc;
  logic               skip;
  logic               flow;
  logic [1:0]         extra;
  logic [8:0]         sum9;
  logic [4:0]         sum5;

  assign busy = (s.st != ctd_pkg::st_idle);

  ctd_phase u_phase (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (busy),
    .phase    (phase),
    .cyc_end  (cyc_end)
  );

  ctd_file_ram u_ram (
    .core_clk (core_clk),
    .rd_en    (rd_en),
    .rd_addr  (rd_addr),
    .wr       (wr),
    .rd_data  (rd_data)
  );

  // operand decode: all fields come from the one held word
  always_comb begin
    cat     = s.ir[`CTD_CAT];
    op      = s.ir[`CTD_OP];
    is_file = (cat == `CTD_CAT_BYTE) || (cat == `CTD_CAT_BIT);
    is_st   = (cat == `CTD_CAT_LIT) && ((op == `CTD_OP_STMODE) || (op == `CTD_OP_STOFFS));
    psel    = (op == `CTD_OP_STMODE) ? s.ir[`CTD_N_MM] : s.ir[`CTD_N_K];
    ind     = 1'b0;
    ea      = {9'h000, s.ir[`CTD_FILE]};
    ptr_new = 16'h0000;
    if (is_file) begin
      // window addresses have no storage of their own
      if (s.ir[`CTD_FILE] == `CTD_WIN0) begin
        ind = 1'b1;
        ea  = s.ptr0;
      end else if (s.ir[`CTD_FILE] == `CTD_WIN1) begin
        ind = 1'b1;
        ea  = s.ptr1;
      end
      ptr = s.ptr0;
    end else begin
      ptr = psel ? s.ptr1 : s.ptr0;
    end
    if (is_st) begin
      if (op == `CTD_OP_STOFFS) begin
        ea      = ptr + {{10{s.ir[5]}}, s.ir[`CTD_K6]};
        ptr_new = ptr;
      end else begin
        unique case (s.ir[`CTD_MM])
          `CTD_MM_PREINC: begin
            ea      = ptr + 16'h0001;
            ptr_new = ptr + 16'h0001;
          end
          `CTD_MM_PREDEC: begin
            ea      = ptr - 16'h0001;
            ptr_new = ptr - 16'h0001;
          end
          `CTD_MM_POSTINC: begin
            ea      = ptr;
            ptr_new = ptr + 16'h0001;
          end
          `CTD_MM_POSTDEC: begin
            ea      = ptr;
            ptr_new = ptr - 16'h0001;
          end
        endcase
      end
    end
    // upper half of pointer space is program memory: reads as zero, ignores stores
    pm   = (ind || is_st) && ea[`CTD_PM_BIT];
    opnd = pm ? 8'h00 : rd_data;
  end

  // result and flow
  always_comb begin
    res     = opnd;
    to_file = 1'b0;
    to_acc  = 1'b0;
    skip    = 1'b0;
    flow    = 1'b0;
    sum9    = {1'b0, s.acc} + {1'b0, opnd};
    sum5    = {1'b0, s.acc[3:0]} + {1'b0, opnd[3:0]};
    if (cat == `CTD_CAT_BYTE) begin
      to_file = s.ir[`CTD_DEST];
      to_acc  = !s.ir[`CTD_DEST];
      unique case (op)
        `CTD_OP_INCF:  res = opnd + 8'h01;
        `CTD_OP_DECF:  res = opnd - 8'h01;
        `CTD_OP_CLRF:  begin
          res     = 8'h00;
          to_file = 1'b1;
          to_acc  = 1'b0;
        end
        `CTD_OP_ADDWF: res = sum9[7:0];
        `CTD_OP_DECSZ: begin
          res  = opnd - 8'h01;
          skip = (res == 8'h00);
        end
        `CTD_OP_INCSZ: begin
          res  = opnd + 8'h01;
          skip = (res == 8'h00);
        end
        `CTD_OP_MOVWF: begin
          res     = s.acc;
          to_file = 1'b1;
          to_acc  = 1'b0;
        end
        default:       res = opnd;
      endcase
    end else if (cat == `CTD_CAT_BIT) begin
      unique case (s.ir[`CTD_BOP])
        `CTD_BOP_SET: begin
          res     = opnd | (8'h01 << s.ir[`CTD_BIT]);
          to_file = 1'b1;
        end
        `CTD_BOP_CLR: begin
          res     = opnd & ~(8'h01 << s.ir[`CTD_BIT]);
          to_file = 1'b1;
        end
        `CTD_BOP_SKIPCLR: skip = !opnd[s.ir[`CTD_BIT]];
        `CTD_BOP_SKIPSET: skip = opnd[s.ir[`CTD_BIT]];
      endcase
    end else if (cat == `CTD_CAT_CTRL) begin
      flow = (op >= `CTD_OP_JUMP) && (op <= `CTD_OP_BRANCHW);
    end
    flow  = flow || skip;
    extra = {1'b0, flow} + {1'b0, pm};
  end

  // file ram: read in the first quarter, store in the last
  always_comb begin
    rd_en   = (s.st == ctd_pkg::st_first) && (phase == 2'h0) && is_file && !pm;
    rd_addr = ea[6:0];
    wr      = '0;
    if ((s.st == ctd_pkg::st_first) && cyc_end && !pm) begin
      if ((is_file && to_file) || is_st) begin
        wr.we   = 1'b1;
        wr.addr = ea[6:0];
        wr.data = is_st ? s.acc : res;
      end
    end
  end

  always_comb begin
    n = s;
    // bus slave: one wait state on every access
    if (s.bus.pend) begin
      n.bus.pend = 1'b0;
      n.hready   = 1'b1;
      n.hrdata   = 32'h0000_0000;
      unique case (s.bus.idx)
        `CTD_ADDR_INSTR: n.hrdata = {18'h00000, s.ir};
        `CTD_ADDR_ACC:   n.hrdata = {24'h000000, s.acc};
        `CTD_ADDR_PTR0:  n.hrdata = {16'h0000, s.ptr0};
        `CTD_ADDR_PTR1:  n.hrdata = {16'h0000, s.ptr1};
        `CTD_ADDR_STAT:  n.hrdata = {25'h0000000, s.last_cyc, s.dc, s.c, s.z, busy};
        `CTD_ADDR_PC:    n.hrdata = {21'h000000, s.pc};
        default:         n.hrdata = 32'h0000_0000;
      endcase
      // writes while busy are dropped so software never races the sequencer
      if (s.bus.wr && !busy) begin
        unique case (s.bus.idx)
          `CTD_ADDR_INSTR: begin
            n.ir = hwdata[13:0];
            n.st = ctd_pkg::st_first;
          end
          `CTD_ADDR_ACC:   n.acc  = hwdata[7:0];
          `CTD_ADDR_PTR0:  n.ptr0 = hwdata[15:0];
          `CTD_ADDR_PTR1:  n.ptr1 = hwdata[15:0];
          `CTD_ADDR_PC:    n.pc   = hwdata[10:0];
          default:         n.hresp = 1'b0;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      n.bus.pend = 1'b1;
      n.bus.wr   = hwrite && (hsize == `CTD_HSIZE_WORD) && (haddr[31:8] == 24'h000000);
      n.bus.idx  = (haddr[31:8] == 24'h000000) ? haddr[7:2] : 6'h3f;
      n.hready   = 1'b0;
    end
    // execute at the end of each instruction's first instruction cycle
    if (cyc_end && (s.st == ctd_pkg::st_first)) begin
      n.pc = s.pc + (skip ? 11'h002 : 11'h001);
      if (is_file && to_acc) begin
        n.acc = res;
      end
      if (cat == `CTD_CAT_BYTE) begin
        if ((op == `CTD_OP_MOVF) || (op == `CTD_OP_INCF) || (op == `CTD_OP_DECF) ||
            (op == `CTD_OP_CLRF) || (op == `CTD_OP_ADDWF)) begin
          n.z = (res == 8'h00);
        end
        if (op == `CTD_OP_ADDWF) begin
          n.c  = sum9[8];
          n.dc = sum5[4];
        end
      end
      if (cat == `CTD_CAT_CTRL) begin
        unique case (op)
          `CTD_OP_JUMP:    n.pc = s.ir[`CTD_K11];
          `CTD_OP_CALL: begin
            n.stk = s.pc + 11'h001;
            n.pc  = s.ir[`CTD_K11];
          end
          `CTD_OP_COMPUTED_SUBROUTINE_JUMP: begin
            n.stk = s.pc + 11'h001;
            n.pc  = {3'h0, s.acc};
          end
          `CTD_OP_RET:     n.pc = s.stk;
          `CTD_OP_RETLIT: begin
            n.pc  = s.stk;
            n.acc = s.ir[`CTD_K8];
          end
          `CTD_OP_RETINT:  n.pc = s.stk;
          `CTD_OP_BRANCH:  n.pc = s.pc + 11'h001 + {{2{s.ir[8]}}, s.ir[`CTD_K9]};
          `CTD_OP_BRANCHW: n.pc = s.pc + 11'h001 + {3'h0, s.acc};
          default:         n.pc = s.pc + 11'h001;
        endcase
      end
      if (cat == `CTD_CAT_LIT) begin
        if (op == `CTD_OP_MOVLW) begin
          n.acc = s.ir[`CTD_K8];
        end else if (is_st) begin
          // pointer takes ptr_new, which offset mode leaves unchanged; status flags deliberately untouched
          if (psel) begin
            n.ptr1 = ptr_new;
          end else begin
            n.ptr0 = ptr_new;
          end
        end
      end
      n.last_cyc = 3'h1 + {1'b0, extra};
      if (extra == 2'h0) begin
        n.st = ctd_pkg::st_idle;
      end else begin
        n.cyc_left = extra - 2'h1;
        n.st       = ctd_pkg::st_extra;
      end
    end else if (cyc_end && (s.st == ctd_pkg::st_extra)) begin
      // flushed cycle: nothing but time passes
      if (s.cyc_left == 2'h0) begin
        n.st = ctd_pkg::st_idle;
      end else begin
        n.cyc_left = s.cyc_left - 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s        <= '0;
      s.hready <= 1'b1;
      s.acc    <= `CTD_RST_ACC;
      s.ptr0   <= `CTD_RST_PTR;
      s.ptr1   <= `CTD_RST_PTR;
      s.pc     <= `CTD_RST_PC;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hready;
  assign hrdata    = s.hrdata;
  assign hresp     = s.hresp;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic started;
  // first quarter of the first instruction cycle marks a fresh start
  assign started = (s.st == ctd_pkg::st_first) && (phase == 2'h0);

  a_word_fetch: assert property (started |-> s.ir == $past(hwdata[13:0]))
    else $error("instruction word not taken from the bus write");
  a_call_two_cyc: assert property (started && (cat == `CTD_CAT_CTRL) &&
      ((op == `CTD_OP_CALL) || (op == `CTD_OP_COMPUTED_SUBROUTINE_JUMP)) |-> busy[*8] ##1 !busy)
    else $error("call did not take two instruction cycles");
  a_ret_two_cyc: assert property (started && (cat == `CTD_CAT_CTRL) &&
      (op >= `CTD_OP_RET) && (op <= `CTD_OP_RETINT) |-> busy[*8] ##1 !busy)
    else $error("return did not take two instruction cycles");
  a_jump_two_cyc: assert property (started && (cat == `CTD_CAT_CTRL) &&
      (op == `CTD_OP_JUMP) |-> busy[*8] ##1 (!busy && s.pc == $past(s.ir[`CTD_K11], 8)))
    else $error("jump timing or target wrong");
  a_pm_extra: assert property (cyc_end && (s.st == ctd_pkg::st_first) && pm |=>
      (s.st == ctd_pkg::st_extra))
    else $error("program space access gained no extra cycle");
  a_phase_span: assert property (cyc_end |=> (!cyc_end)[*3] ##1 (cyc_end || !busy))
    else $error("instruction cycle is not four clocks");
  a_rmw_read: assert property (wr.we && is_file |-> $past(rd_en, 3))
    else $error("file store without preceding read");
  a_dest_acc: assert property (cyc_end && (s.st == ctd_pkg::st_first) && (cat == `CTD_CAT_BYTE) &&
      !s.ir[`CTD_DEST] && (op != `CTD_OP_MOVWF) && (op != `CTD_OP_CLRF) |-> !wr.we ##1 s.acc == $past(res))
    else $error("destination zero did not go to accumulator");
  a_store_data: assert property (cyc_end && (s.st == ctd_pkg::st_first) && is_st && !pm |->
      wr.we && (wr.data == s.acc) && (wr.addr == ea[6:0]))
    else $error("indirect store wrote wrong data or address");
  a_ptr_wrap: assert property (cyc_end && (s.st == ctd_pkg::st_first) && is_st &&
      (op == `CTD_OP_STMODE) && (s.ir[`CTD_MM] == `CTD_MM_PREINC) && (ptr == 16'hffff) |=>
      (psel ? s.ptr1 : s.ptr0) == 16'h0000)
    else $error("pointer did not wrap");
  a_flags_hold: assert property (cyc_end && (s.st == ctd_pkg::st_first) && is_st |=>
      {s.z, s.c, s.dc} == $past({s.z, s.c, s.dc}))
    else $error("indirect store changed status flags");
  a_nop_one_cyc: assert property (started && (s.ir == 14'h2000) |->
      busy[*4] ##1 (!busy && s.acc == $past(s.acc, 5) && s.z == $past(s.z, 5)))
    else $error("no-operation took wrong time or changed state");

  c_call: cover property (started && (cat == `CTD_CAT_CTRL) && (op == `CTD_OP_CALL));
  c_store: cover property (cyc_end && (s.st == ctd_pkg::st_first) && is_st && !pm);
  c_skip: cover property (cyc_end && (s.st == ctd_pkg::st_first) && skip);
  c_pm_three: cover property (cyc_end && (s.st == ctd_pkg::st_first) && pm && flow);
endmodule // ctd_core

//--- ctd_bus_master.sv
`timescale 1ns/10ps
module ctd_bus_master (
  input  wire logic        core_clk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // entered just after a rising edge; no wait count is assumed, the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    // reads get toggled data so a stale word never looks like a write
    hwdata <= wr ? d : ~hwdata;
    do @(posedge core_clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
endmodule // ctd_bus_master

//--- cpu_instruction_timing_decode_bench.sv
`timescale 1ns/10ps
module cpu_instruction_timing_decode_bench;
  localparam logic [31:0] A_INSTR = 32'h00;
  localparam logic [31:0] A_ACC   = 32'h04;
  localparam logic [31:0] A_PTR0  = 32'h08;
  localparam logic [31:0] A_PTR1  = 32'h0c;
  localparam logic [31:0] A_STAT  = 32'h10;
  localparam logic [31:0] A_PC    = 32'h14;
  logic        core_clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [31:0] pa;
  int          n_fail;
  int          checks_done;
  logic [15:0] exp_ptr [4] = '{16'h0041, 16'h003f, 16'h0041, 16'h003f};
  logic [6:0]  exp_loc [4] = '{7'h41, 7'h3f, 7'h40, 7'h40};

  ctd_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp)
  );
  ctd_bus_master bus (
    .core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata)
  );

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus.xfer(1'h1, a, d, q);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus.xfer(1'h0, a, 32'h0, q);
    check(q, exp, what);
    check({31'h0, hresp}, 32'h0, "hresp");
  endtask

  // busy is polled rather than timed; the cycle count checked is the last_cyc field the core reports in the status word
  task automatic run(input logic [13:0] ins, input logic [2:0] ncyc);
    int k;
    wr(A_INSTR, {18'h0, ins});
    k = 0;
    do begin
      bus.xfer(1'h0, A_STAT, 32'h0, q);
      k++;
    end while (q[0] !== 1'h0 && k < 40);
    check({28'h0, q[6:4], q[0]}, {28'h0, ncyc, 1'h0}, "cycles");
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    rst_n = 1'h0;
    n_fail = 0;
    checks_done = 0;
    pa = 32'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    rd(A_ACC, 32'h0, "acc");
    rd(A_PTR0, 32'h0, "ptr0");
    rd(A_PTR1, 32'h0, "ptr1");
    rd(A_STAT, 32'h0, "stat");
    rd(A_PC, 32'h0, "pc");
    rd(32'h100, 32'h0, "unmapped");
    run(14'h2000, 3'h1);
    rd(A_PC, 32'h1, "pc");
    rd(A_STAT, 32'h10, "stat");
    run(14'h205a, 3'h1);
    rd(A_PC, 32'h2, "pc");
    rd(A_ACC, 32'h0, "acc");
    run(14'h3041, 3'h1);
    run(14'h07a0, 3'h1);
    run(14'h0120, 3'h1);
    rd(A_ACC, 32'h42, "acc");
    run(14'h0020, 3'h1);
    rd(A_ACC, 32'h41, "acc");
    run(14'h01a0, 3'h1);
    run(14'h0020, 3'h1);
    rd(A_ACC, 32'h42, "acc");
    run(14'h07ff, 3'h1);
    run(14'h3000, 3'h1);
    run(14'h007f, 3'h1);
    rd(A_ACC, 32'h42, "acc");
    run(14'h3001, 3'h1);
    run(14'h07a1, 3'h1);
    run(14'h05a1, 3'h2);
    run(14'h06a1, 3'h1);
    rd(A_PC, 32'h10, "pc");
    run(14'h11a1, 3'h1);
    run(14'h19a1, 3'h1);
    run(14'h1da1, 3'h2);
    run(14'h0021, 3'h1);
    rd(A_ACC, 32'h09, "acc");
    run(14'h1421, 3'h1);
    run(14'h1821, 3'h2);
    rd(A_PC, 32'h18, "pc");
    run(14'h2140, 3'h2);
    rd(A_PC, 32'h140, "pc");
    run(14'h2250, 3'h2);
    rd(A_PC, 32'h250, "pc");
    run(14'h2400, 3'h2);
    rd(A_PC, 32'h141, "pc");
    run(14'h2300, 3'h2);
    run(14'h2555, 3'h2);
    rd(A_PC, 32'h142, "pc");
    rd(A_ACC, 32'h55, "acc");
    run(14'h2600, 3'h2);
    wr(A_PC, 32'h10);
    run(14'h27fe, 3'h2);
    run(14'h2800, 3'h2);
    rd(A_PC, 32'h65, "pc");
    for (int m = 0; m < 4; m++) begin
      pa = A_PTR0 + {29'h0, m[0], 2'h0};
      wr(pa, 32'h40);
      run(14'h3050 + 14'(m), 3'h1);
      run(14'h3100 + {11'h0, m[0], m[1:0]}, 3'h1);
      rd(pa, {16'h0, exp_ptr[m]}, "ptr");
      run({7'h0, exp_loc[m]}, 3'h1);
      rd(A_ACC, 32'h50 + 32'(m), "acc");
    end
    run(14'h03a2, 3'h1);
    rd(A_STAT, 32'h12, "stat");
    wr(A_PTR1, 32'hffff);
    run(14'h3066, 3'h1);
    run(14'h3104, 3'h1);
    rd(A_PTR1, 32'h0, "ptr1");
    rd(A_STAT, 32'h12, "stat");
    run(14'h0001, 3'h1);
    rd(A_ACC, 32'h66, "acc");
    wr(A_PTR0, 32'h0);
    run(14'h3101, 3'h2);
    rd(A_PTR0, 32'hffff, "ptr0");
    run(14'h0000, 3'h2);
    rd(A_ACC, 32'h0, "acc");
    wr(A_PTR0, 32'h11);
    wr(A_PTR1, 32'h60);
    run(14'h3077, 3'h1);
    run(14'h321f, 3'h1);
    run(14'h3012, 3'h1);
    run(14'h3260, 3'h1);
    rd(A_PTR0, 32'h11, "ptr0");
    rd(A_PTR1, 32'h60, "ptr1");
    run(14'h0030, 3'h1);
    rd(A_ACC, 32'h77, "acc");
    run(14'h0040, 3'h1);
    rd(A_ACC, 32'h12, "acc");
    tally_and_finish();
  end
endmodule // cpu_instruction_timing_decode_bench
